// *** tpe_timer.sv ***
/*
  16-bit timer with per-channel input capture, output compare, edge-aligned
  and center-aligned PWM, with byte-wide coherent registers on APB.
  Assumes pins and debug_halt are synchronous to pclk; ext_tick is a one-cycle
  enable used as the external count source.
*/
// The APB slave port and the register offsets were left to the implementer.
`default_nettype none
module tpe_timer
  import tpe_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debug_halt,
  input wire logic ext_tick,
  input wire logic [NUM_CH-1:0] ch_in,
  output logic [NUM_CH-1:0] ch_out,
  output logic [NUM_CH-1:0] ch_oe,
  output logic wrap_irq,
  output logic [NUM_CH-1:0] ch_irq
);

  typedef struct packed {
    tpe_tsc_type tsc;
    logic wrap_armed;
    logic [15:0] cnt;
    logic [7:0] pre;
    logic up;
    logic [15:0] modulo;
    logic [7:0] mbuf_hi;
    logic [7:0] mbuf_lo;
    logic mhi_wr;
    logic mlo_wr;
    logic cl_v;
    logic cl_lo_first;
    logic [15:0] cl;
    logic [15:0] snap;
    logic [7:0] rdat;
  } tpe_core_type;

  typedef struct packed {
    tpe_core_type k;
    tpe_ch_type [NUM_CH-1:0] ch;
  } tpe_state_type;

  tpe_state_type s_r;
  tpe_state_type s_nxt;
  logic tick;
  logic wrap_ev;
  logic pwm_pt;
  logic mapped;
  logic [15:0] term;
  logic acc_wr;
  logic acc_rd;
  logic setup_rd;

  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = {24'h000000, s_r.k.rdat};
  assign wrap_irq = s_r.k.tsc.counter_wrap_flag & s_r.k.tsc.wrap_irq_enable;
  assign term = (s_r.k.modulo == TPE_CNT_RST) ? TPE_FREE_TERM : s_r.k.modulo;

  // ==========================================================================
  // Next state
  always_comb begin
    tpe_ch_type c;
    logic [7:0] base;
    logic [7:0] pre_div;
    logic [7:0] wb;
    logic [7:0] rdb;
    logic [15:0] snapv;
    logic capture;
    logic cas;
    logic clk_on;
    logic ev;
    logic cap;
    logic active;
    c = '0;
    base = 8'h00;
    wb = pwdata[7:0];
    rdb = 8'h00;
    snapv = 16'h0000;
    capture = 1'b0;
    ev = 1'b0;
    cap = 1'b0;
    active = 1'b0;
    s_nxt = s_r;
    tick = 1'b0;
    wrap_ev = 1'b0;
    mapped = 1'b0;
    cas = s_r.k.tsc.center_align_select;
    clk_on = s_r.k.tsc.clock_source_select != TPE_CLKS_OFF;
    pre_div = 8'((16'h0001 << s_r.k.tsc.prescale) - 16'h0001);

    // Prescaler and counter freeze while the core is halted
    if (clk_on && !debug_halt &&
        (s_r.k.tsc.clock_source_select != TPE_CLKS_EXT || ext_tick)) begin
      if (s_r.k.pre == pre_div) begin
        s_nxt.k.pre = TPE_PRE_RST;
        tick = 1'b1;
      end else begin
        s_nxt.k.pre = s_r.k.pre + 8'h01;
      end
    end
    if (tick) begin
      if (!cas) begin
        if (s_r.k.cnt == term) begin
          s_nxt.k.cnt = TPE_CNT_RST;
          wrap_ev = 1'b1;
        end else begin
          s_nxt.k.cnt = s_r.k.cnt + 16'h0001;
        end
      end else if (s_r.k.up) begin
        if (s_r.k.cnt >= s_r.k.modulo) begin
          s_nxt.k.up = 1'b0;
          s_nxt.k.cnt = s_r.k.cnt - 16'h0001;
          wrap_ev = 1'b1;
        end else begin
          s_nxt.k.cnt = s_r.k.cnt + 16'h0001;
        end
      end else if (s_r.k.cnt == TPE_CNT_RST) begin
        s_nxt.k.up = 1'b1;
        s_nxt.k.cnt = 16'h0001;
      end else begin
        s_nxt.k.cnt = s_r.k.cnt - 16'h0001;
      end
    end
    // Buffered PWM values load on the step into the terminal count
    pwm_pt = tick && (s_r.k.up || !cas) && s_r.k.cnt == term - 16'h0001;

    // Timer-level register accesses
    if (paddr == TPE_OFF_TSC) begin
      mapped = 1'b1;
      rdb = s_r.k.tsc;
    end else if (paddr == TPE_OFF_CNT_HI || paddr == TPE_OFF_CNT_LO) begin
      mapped = 1'b1;
      snapv = s_r.k.cnt;
      if (s_r.k.cl_v && !debug_halt) begin
        rdb = (paddr == TPE_OFF_CNT_HI) ? s_r.k.cl[15:8] : s_r.k.cl[7:0];
      end else begin
        rdb = (paddr == TPE_OFF_CNT_HI) ? s_r.k.cnt[15:8] : s_r.k.cnt[7:0];
      end
    end else if (paddr == TPE_OFF_MOD_HI || paddr == TPE_OFF_MOD_LO) begin
      mapped = 1'b1;
      rdb = (paddr == TPE_OFF_MOD_HI) ? s_r.k.modulo[15:8] : s_r.k.modulo[7:0];
    end
    if (acc_wr && paddr == TPE_OFF_TSC) begin
      s_nxt.k.tsc.wrap_irq_enable = wb[6];
      s_nxt.k.tsc.center_align_select = wb[5];
      s_nxt.k.tsc.clock_source_select = wb[4:3];
      s_nxt.k.tsc.prescale = wb[2:0];
      if (!wb[7] && s_r.k.wrap_armed) begin
        s_nxt.k.tsc.counter_wrap_flag = 1'b0;
      end
      s_nxt.k.wrap_armed = 1'b0;
      s_nxt.k.mhi_wr = 1'b0;
      s_nxt.k.mlo_wr = 1'b0;
      if (debug_halt) begin
        s_nxt.k.cl_v = 1'b0;
      end
    end
    if (acc_wr && (paddr == TPE_OFF_CNT_HI || paddr == TPE_OFF_CNT_LO)) begin
      s_nxt.k.cnt = TPE_CNT_RST;
      s_nxt.k.pre = TPE_PRE_RST;
      s_nxt.k.up = 1'b1;
      s_nxt.k.cl_v = 1'b0;
    end
    if (acc_wr && paddr == TPE_OFF_MOD_HI) begin
      s_nxt.k.mbuf_hi = wb;
      s_nxt.k.mhi_wr = 1'b1;
    end
    if (acc_wr && paddr == TPE_OFF_MOD_LO) begin
      s_nxt.k.mbuf_lo = wb;
      s_nxt.k.mlo_wr = 1'b1;
    end
    // Modulo takes effect on the next count (at once with the clock off), so a period in progress can be cut short
    if (s_r.k.mhi_wr && s_r.k.mlo_wr && (!clk_on || tick)) begin
      s_nxt.k.modulo = {s_r.k.mbuf_hi, s_r.k.mbuf_lo};
      s_nxt.k.mhi_wr = 1'b0;
      s_nxt.k.mlo_wr = 1'b0;
    end
    if (acc_rd && paddr == TPE_OFF_TSC && s_r.k.tsc.counter_wrap_flag) begin
      s_nxt.k.wrap_armed = 1'b1;
    end
    // Reading one counter byte freezes the other for a coherent 16-bit read
    if (acc_rd && !debug_halt && (paddr == TPE_OFF_CNT_HI || paddr == TPE_OFF_CNT_LO)) begin
      if (!s_r.k.cl_v) begin
        s_nxt.k.cl_v = 1'b1;
        s_nxt.k.cl = s_r.k.snap;
        s_nxt.k.cl_lo_first = paddr == TPE_OFF_CNT_LO;
      end else if ((paddr == TPE_OFF_CNT_LO) != s_r.k.cl_lo_first) begin
        s_nxt.k.cl_v = 1'b0;
      end
    end
    if (wrap_ev) begin
      s_nxt.k.tsc.counter_wrap_flag = 1'b1;
      s_nxt.k.wrap_armed = 1'b0;
    end

    // ========================================================================
    // Channels
    for (int i = 0; i < NUM_CH; i++) begin
      c = s_r.ch[i];
      base = 8'(TPE_OFF_CH_BASE + 8'(i) * TPE_CH_STRIDE);
      capture = !cas && c.mode == TPE_MS_CAPTURE;
      ev = 1'b0;
      if (capture) begin
        cap = (c.edge_level_select == TPE_ELS_RISE && ch_in[i] && !c.in_prev) ||
              (c.edge_level_select == TPE_ELS_FALL && !ch_in[i] && c.in_prev) ||
              (c.edge_level_select == TPE_ELS_BOTH && ch_in[i] != c.in_prev);
        if (cap) begin
          c.val = s_r.k.cnt;
          ev = 1'b1;
        end
      end else if (tick && s_nxt.k.cnt == s_r.ch[i].val) begin
        ev = 1'b1;
      end
      c.in_prev = ch_in[i];
      if (cas) begin
        // Duty latched at the period boundary, so changes wait a period
        if (wrap_ev) begin
          c.duty = c.val;
        end
        active = !c.duty[15] && c.duty != 16'h0000 &&
                 (s_nxt.k.cnt < c.duty || c.duty >= s_r.k.modulo);
        c.out = c.edge_level_select[0] ? !active : active;
      end else if (c.mode == TPE_MS_COMPARE) begin
        if (ev) begin
          case (c.edge_level_select)
            TPE_ELS_RISE: c.out = !c.out;
            TPE_ELS_FALL: c.out = 1'b0;
            TPE_ELS_BOTH: c.out = 1'b1;
            default: c.out = c.out;
          endcase
        end
      end else if (c.mode[1]) begin
        if (wrap_ev) begin
          c.out = !c.edge_level_select[0];
        end
        if (ev) begin
          c.out = c.edge_level_select[0];
        end
      end
      if (c.hi_wr && c.lo_wr && (!clk_on ||
          (!cas && c.mode == TPE_MS_COMPARE && tick) ||
          ((cas || c.mode[1]) && pwm_pt))) begin
        c.val = {c.buf_hi, c.buf_lo};
        c.hi_wr = 1'b0;
        c.lo_wr = 1'b0;
      end
      if (paddr == base + TPE_CH_SC) begin
        mapped = 1'b1;
        rdb = {s_r.ch[i].channel_event_flag, s_r.ch[i].channel_irq_enable,
               s_r.ch[i].mode, s_r.ch[i].edge_level_select, 2'b00};
      end else if (paddr == base + TPE_CH_VH || paddr == base + TPE_CH_VL) begin
        mapped = 1'b1;
        snapv = s_r.ch[i].val;
        if (s_r.ch[i].lat_v && !debug_halt) begin
          rdb = (paddr == base + TPE_CH_VH) ? s_r.ch[i].lat[15:8] : s_r.ch[i].lat[7:0];
        end else begin
          rdb = (paddr == base + TPE_CH_VH) ? s_r.ch[i].val[15:8] : s_r.ch[i].val[7:0];
        end
      end
      if (acc_wr && paddr == base + TPE_CH_SC) begin
        c.channel_irq_enable = wb[6];
        c.mode = wb[5:4];
        c.edge_level_select = wb[3:2];
        if (!wb[7] && s_r.ch[i].armed) begin
          c.channel_event_flag = 1'b0;
        end
        c.armed = 1'b0;
        c.lat_v = 1'b0;
        c.hi_wr = 1'b0;
        c.lo_wr = 1'b0;
      end
      if (acc_wr && !capture && paddr == base + TPE_CH_VH) begin
        c.buf_hi = wb;
        c.hi_wr = 1'b1;
      end
      if (acc_wr && !capture && paddr == base + TPE_CH_VL) begin
        c.buf_lo = wb;
        c.lo_wr = 1'b1;
      end
      if (acc_rd && paddr == base + TPE_CH_SC && s_r.ch[i].channel_event_flag) begin
        c.armed = 1'b1;
      end
      if (acc_rd && !debug_halt && (paddr == base + TPE_CH_VH || paddr == base + TPE_CH_VL)) begin
        if (!s_r.ch[i].lat_v) begin
          c.lat_v = 1'b1;
          c.lat = s_r.k.snap;
          c.lat_lo_first = paddr == base + TPE_CH_VL;
        end else if ((paddr == base + TPE_CH_VL) != s_r.ch[i].lat_lo_first) begin
          c.lat_v = 1'b0;
        end
      end
      if (ev) begin
        c.channel_event_flag = 1'b1;
        c.armed = 1'b0;
      end
      s_nxt.ch[i] = c;
      ch_irq[i] = s_r.ch[i].channel_event_flag & s_r.ch[i].channel_irq_enable;
      ch_out[i] = s_r.ch[i].out;
      ch_oe[i] = (cas || s_r.ch[i].mode != TPE_MS_CAPTURE) &&
                 s_r.ch[i].edge_level_select != 2'b00;
    end
    // Read data is registered in the setup cycle so access needs no wait state
    if (setup_rd) begin
      s_nxt.k.rdat = rdb;
      s_nxt.k.snap = snapv;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_WRAP_EDGE: assert property (
    !s_r.k.tsc.center_align_select && tick && s_r.k.cnt == term && !acc_wr
    |=> s_r.k.tsc.counter_wrap_flag && s_r.k.cnt == 16'h0000)
    else $error("wrap flag not set at terminal count");
  AST_WRAP_CENTER: assert property (
    s_r.k.tsc.center_align_select && tick && s_r.k.up && s_r.k.cnt == s_r.k.modulo && !acc_wr
    |=> s_r.k.tsc.counter_wrap_flag && !s_r.k.up)
    else $error("wrap flag not set at direction change");
  AST_CNT_CLEAR: assert property (
    acc_wr && (paddr == TPE_OFF_CNT_HI || paddr == TPE_OFF_CNT_LO)
    |=> s_r.k.cnt == 16'h0000 && s_r.k.pre == 8'h00)
    else $error("counter write did not clear counter and prescaler");
  AST_HALT_READ: assert property (
    debug_halt && setup_rd && paddr == TPE_OFF_CNT_LO
    |=> prdata[7:0] == $past(s_r.k.cnt[7:0]))
    else $error("halted counter read not live");
  AST_CAPTURE_NOWRITE: assert property (
    acc_wr && paddr == TPE_OFF_CH_BASE + TPE_CH_VH && !s_r.k.tsc.center_align_select &&
    s_r.ch[0].mode == TPE_MS_CAPTURE
    |=> s_r.ch[0].buf_hi == $past(s_r.ch[0].buf_hi))
    else $error("value write accepted in capture mode");
  AST_COMPARE_FLAG: assert property (
    !s_r.k.tsc.center_align_select && s_r.ch[0].mode == TPE_MS_COMPARE && tick &&
    s_nxt.k.cnt == s_r.ch[0].val
    |=> s_r.ch[0].channel_event_flag)
    else $error("compare match did not set channel flag");
  AST_FLAG_HOLD: assert property (
    s_r.k.tsc.counter_wrap_flag && !(acc_wr && paddr == TPE_OFF_TSC)
    |=> s_r.k.tsc.counter_wrap_flag)
    else $error("wrap flag lost without a clear");
  AST_IRQ_LEVEL: assert property (
    s_r.ch[0].channel_event_flag && s_r.ch[0].channel_irq_enable |-> ch_irq[0])
    else $error("channel interrupt not asserted");
  AST_FULL_DUTY: assert property (
    s_r.k.tsc.center_align_select && s_r.k.modulo != 16'h0000 && !s_r.k.modulo[15] &&
    s_r.ch[0].duty == s_r.k.modulo && s_r.ch[0].edge_level_select == TPE_ELS_FALL
    ##1 $stable(s_r.ch[0].duty) |-> ch_out[0])
    else $error("center PWM at modulo not full duty");
endmodule
`default_nettype wire

// *** tpe_pkg.sv ***
/*
  Constants and types shared by the timer/PWM block: register offsets on the
  APB byte-wide register map, field layouts, mode encodings and reset values.
  Assumes a 32-bit APB with each 8-bit register in the low byte of one word.
*/
`default_nettype none
package tpe_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] TPE_OFF_TSC = 8'h00;
  localparam logic [7:0] TPE_OFF_CNT_HI = 8'h04;
  localparam logic [7:0] TPE_OFF_CNT_LO = 8'h08;
  localparam logic [7:0] TPE_OFF_MOD_HI = 8'h0C;
  localparam logic [7:0] TPE_OFF_MOD_LO = 8'h10;
  localparam logic [7:0] TPE_OFF_CH_BASE = 8'h14;
  localparam logic [7:0] TPE_CH_STRIDE = 8'h0C;
  localparam logic [7:0] TPE_CH_SC = 8'h00;
  localparam logic [7:0] TPE_CH_VH = 8'h04;
  localparam logic [7:0] TPE_CH_VL = 8'h08;

  // ==========================================================================
  // Field encodings and reset values
  localparam logic [1:0] TPE_CLKS_OFF = 2'h0;
  localparam logic [1:0] TPE_CLKS_EXT = 2'h3;
  localparam logic [1:0] TPE_MS_CAPTURE = 2'h0;
  localparam logic [1:0] TPE_MS_COMPARE = 2'h1;
  localparam logic [1:0] TPE_ELS_RISE = 2'h1;
  localparam logic [1:0] TPE_ELS_FALL = 2'h2;
  localparam logic [1:0] TPE_ELS_BOTH = 2'h3;
  localparam logic [15:0] TPE_CNT_RST = 16'h0000;
  localparam logic [15:0] TPE_FREE_TERM = 16'hFFFF;
  localparam logic [7:0] TPE_PRE_RST = 8'h00;

  // ==========================================================================
  // Register layouts
  typedef struct packed {
    logic counter_wrap_flag;
    logic wrap_irq_enable;
    logic center_align_select;
    logic [1:0] clock_source_select;
    logic [2:0] prescale;
  } tpe_tsc_type;

  typedef struct packed {
    logic channel_event_flag;
    logic channel_irq_enable;
    logic [1:0] mode;
    logic [1:0] edge_level_select;
    logic armed;
    logic [15:0] val;
    logic [7:0] buf_hi;
    logic [7:0] buf_lo;
    logic hi_wr;
    logic lo_wr;
    logic [15:0] duty;
    logic lat_v;
    logic lat_lo_first;
    logic [15:0] lat;
    logic in_prev;
    logic out;
  } tpe_ch_type;
endpackage
`default_nettype wire

// *** tpe_timer_tb.sv ***
/*
  Self-checking bench for the timer block: APB master tasks, a queue of
  expected read data with a monitor, directed scenarios counted on ext_tick.
  Assumes the zero-wait APB slave and register map of tpe_pkg.
*/
`default_nettype none
module tpe_timer_tb import tpe_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] TSC = TPE_OFF_TSC;
  localparam logic [7:0] C0 = TPE_OFF_CH_BASE;
  localparam logic [7:0] CVH = TPE_OFF_CH_BASE + TPE_CH_VH;
  localparam logic [7:0] CVL = TPE_OFF_CH_BASE + TPE_CH_VL;
  logic pclk, presetn, psel, penable, pwrite, debug_halt, ext_tick;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, wrap_irq;
  logic [1:0] ch_in, ch_out, ch_oe, ch_irq;
  int failures, n_tests;
  integer seed;
  logic [32:0] exp_q[$];

  tpe_timer #(.NUM_CH(2)) u_tpe_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt), .ext_tick(ext_tick),
    .ch_in(ch_in), .ch_out(ch_out), .ch_oe(ch_oe), .wrap_irq(wrap_irq), .ch_irq(ch_irq));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ==========================================================================
  // Checking and closing
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Read data and error flag are judged at the edge that completes the read
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // ==========================================================================
  // APB master and stimulus tasks
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      failures++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    exp_q.push_back({1'b0, 24'h0, d});
    apb(1'b0, a, 8'h00);
  endtask

  // Extra idle edges let registered outputs settle before they are sampled
  task automatic tick(input int n);
    repeat (n) begin
      ext_tick <= 1'b1;
      @(posedge pclk);
      ext_tick <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    logic [7:0] sc;
    logic f;
    seed = 85;
    failures = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    debug_halt = 1'b0;
    ext_tick = 1'b0;
    ch_in = 2'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Every output of both channels starts quiet, the bus answers at once
    check({25'h0, pready, ch_out, ch_oe, ch_irq, wrap_irq}, 33'h080);
    rd(TSC, 8'h00);
    rd(TPE_OFF_CNT_LO, 8'h00);
    rd(TPE_OFF_CNT_HI, 8'h00);
    rd(TPE_OFF_MOD_LO, 8'h00);
    rd(C0, 8'h00);
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 8'hF0, 8'h00);
    wr(TPE_OFF_MOD_HI, 8'h00);
    wr(TPE_OFF_MOD_LO, 8'h03);
    rd(TPE_OFF_MOD_LO, 8'h03);
    // Prescaler by two: a stale prescaler count would step the counter
    wr(TSC, 8'h19);
    wr(TPE_OFF_CNT_HI, 8'h00);
    tick(1);
    wr(TPE_OFF_CNT_LO, 8'h00);
    tick(1);
    rd(TPE_OFF_CNT_LO, 8'h00);
    rd(TPE_OFF_CNT_HI, 8'h00);
    tick(1);
    rd(TPE_OFF_CNT_LO, 8'h01);
    rd(TPE_OFF_CNT_HI, 8'h00);
    wr(TSC, 8'h58);
    wr(TPE_OFF_CNT_LO, 8'h00);
    tick(2);
    rd(TPE_OFF_CNT_HI, 8'h00);
    tick(1);
    debug_halt <= 1'b1;
    @(posedge pclk);
    rd(TPE_OFF_CNT_LO, 8'h03);
    tick(1);
    rd(TPE_OFF_CNT_LO, 8'h03);
    rd(TSC, 8'h58);
    wr(TSC, 8'h58);
    debug_halt <= 1'b0;
    tick(1);
    rd(TPE_OFF_CNT_LO, 8'h00);
    rd(TPE_OFF_CNT_HI, 8'h00);
    rd(TSC, 8'hD8);
    check({32'h0, wrap_irq}, 33'h1);
    tick(4);
    wr(TSC, 8'h58);
    rd(TSC, 8'hD8);
    wr(TSC, 8'h58);
    rd(TSC, 8'h58);
    check({32'h0, wrap_irq}, 33'h0);
    tick(4);
    wr(TSC, 8'h18);
    check({32'h0, wrap_irq}, 33'h0);
    rd(TSC, 8'h98);
    wr(TSC, 8'h18);
    // Capture on channel 0 for each edge choice, counter held at zero
    for (int e = 0; e < 4; e++) begin
      sc = {2'b01, 2'b00, e[1:0], 2'b00};
      wr(C0, sc);
      for (int lv = 1; lv >= 0; lv--) begin
        ch_in[0] <= lv[0];
        repeat (4) @(posedge pclk);
        f = (lv == 1) ? e[0] : e[1];
        rd(C0, {f, sc[6:0]});
        check({31'h0, ch_irq}, {32'h0, f});
        wr(C0, sc);
      end
    end
    wr(CVH, 8'($random(seed)) | 8'h01);
    wr(CVL, 8'($random(seed)) | 8'h01);
    rd(CVH, 8'h00);
    rd(CVL, 8'h00);
    tick(1);
    wr(C0, 8'h54);
    wr(CVH, 8'h00);
    wr(CVL, 8'h03);
    rd(CVH, 8'h00);
    rd(CVL, 8'h00);
    tick(1);
    rd(CVL, 8'h03);
    rd(CVH, 8'h00);
    rd(C0, 8'h54);
    tick(1);
    rd(C0, 8'hD4);
    check({31'h0, ch_out}, 33'h1);
    check({31'h0, ch_oe}, 33'h1);
    wr(C0, 8'h54);
    tick(4);
    rd(C0, 8'hD4);
    check({31'h0, ch_out}, 33'h0);
    wr(C0, 8'h54);
    // Set and clear actions twice each, so a toggle cannot pass for them
    wr(C0, 8'h5C);
    repeat (2) begin
      tick(4);
      rd(C0, 8'hDC);
      check({31'h0, ch_out}, 33'h1);
      wr(C0, 8'h5C);
    end
    wr(C0, 8'h58);
    repeat (2) begin
      tick(4);
      rd(C0, 8'hD8);
      check({31'h0, ch_out}, 33'h0);
      wr(C0, 8'h58);
    end
    wr(C0, 8'h54);
    // Park the compare value out of the count range before entering PWM
    wr(CVH, 8'h00);
    wr(CVL, 8'h10);
    tick(1);
    wr(C0, 8'h68);
    wr(CVH, 8'h00);
    wr(CVL, 8'h01);
    tick(1);
    rd(C0, 8'h68);
    tick(3);
    rd(C0, 8'h68);
    check({31'h0, ch_out}, 33'h1);
    tick(1);
    rd(C0, 8'hE8);
    check({31'h0, ch_out}, 33'h0);
    check({31'h0, ch_irq}, 33'h1);
    wr(C0, 8'h68);
    rd(TSC, 8'h98);
    wr(TSC, 8'h38);
    wr(TPE_OFF_CNT_LO, 8'h00);
    tick(1);
    rd(C0, 8'hE8);
    wr(C0, 8'h68);
    tick(1);
    rd(TSC, 8'h38);
    tick(2);
    rd(TSC, 8'hB8);
    rd(C0, 8'h68);
    tick(1);
    rd(C0, 8'hE8);
    wr(C0, 8'h68);
    wr(TSC, 8'h38);
    wr(CVH, 8'h00);
    wr(CVL, 8'h03);
    tick(5);
    repeat (6) begin
      tick(1);
      check({32'h0, ch_out[0]}, 33'h1);
    end
    rd(CVH, 8'h00);
    wr(CVH, 8'h00);
    wr(CVL, 8'h02);
    tick(5);
    debug_halt <= 1'b1;
    @(posedge pclk);
    rd(CVL, 8'h02);
    wr(C0, 8'h68);
    debug_halt <= 1'b0;
    rd(CVL, 8'h02);
    rd(CVH, 8'h00);
    debug_halt <= 1'b1;
    @(posedge pclk);
    wr(TPE_OFF_MOD_HI, 8'h00);
    wr(TSC, 8'h38);
    wr(TPE_OFF_MOD_LO, 8'h01);
    debug_halt <= 1'b0;
    tick(2);
    rd(TPE_OFF_MOD_LO, 8'h03);
    // Duty changes to and from zero apply only from the next period
    wr(CVH, 8'h00);
    wr(CVL, 8'h00);
    tick(1);
    check({31'h0, ch_out}, 33'h1);
    tick(4);
    check({31'h0, ch_out}, 33'h0);
    wr(CVH, 8'h00);
    wr(CVL, 8'h02);
    tick(3);
    check({31'h0, ch_out}, 33'h0);
    tick(4);
    check({31'h0, ch_out}, 33'h1);
    end_sim();
  end
endmodule
`default_nettype wire
